// ==== pkg/ebl_pkg.sv ====
// Shared types and constants of the external bus lane aligner.
// Assumes one clock domain; sizes and widths are coded as log2 of bytes.
package ebl_pkg;

  // Address width of the internal request
  localparam int ADDR_W = 26;
  // Number of byte lanes on the external data bus
  localparam int LANES = 4;
  // Endian mode pin level that selects big endian
  localparam logic ENDIAN_PIN_BIG = 1'b0;
  // Big endian value of the latched byte order; unused, reset loads it from the pin
  localparam logic BIG_RST = 1'b1;

  // Access size, log2 of the byte count
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } ebl_size_t;

  // External device width, log2 of the byte count
  typedef enum logic [1:0] {
    DW_8  = 2'h0,
    DW_16 = 2'h1,
    DW_32 = 2'h2
  } ebl_width_t;

  // Kind of external device on the selected area
  typedef enum logic [1:0] {
    KIND_NORMAL = 2'h0,
    KIND_SDRAM  = 2'h1,
    KIND_PCMCIA = 2'h2
  } ebl_kind_t;

  // Sequencer states, Gray coded along idle, run, respond
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN  = 2'h1,
    ST_RESP = 2'h3
  } ebl_state_t;

  // One internal access
  typedef struct packed {
    logic              write;
    ebl_size_t         size;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } ebl_req_t;

endpackage

// ==== hw/ebl_lane_align.sv ====
// External bus lane aligner: places internal accesses on byte lanes.
// Assumes the far device answers each cycle with extReady and the
// device width and kind inputs stay stable while an access runs.
//
// Overview of operation
// - Big endian: address 0 is MSB; little endian: address 0 is LSB.
// - Mode pin sampled only during reset; board holds it steady then.
// - Mode pin low at reset gives big endian, high gives little.
// - Ordinary memory may be 8, 16 or 32 bits wide.
// - SDRAM may be only 16 or 32 bits wide.
// - PCMCIA may be only 8 or 16 bits wide.
// - Lane alignment and size conversion happen without software.
// - Access wider than device splits into consecutive narrower cycles.
// - 32-bit big endian: byte k on lane 3-k; words on halves.
// - Longword to 32-bit device: one cycle, all four lanes strobed.
// - 16-bit big endian: even byte lane 1, odd lane 0, word both.
// - Longword to 16-bit big endian: bits 31-16 first, then 15-0.
// - 8-bit device: lane 0 only, MSB first in big endian, LSB first in little, ascending addresses.
`timescale 1ns/100ps
module ebl_lane_align (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // Mode strap
  input  wire logic                        endianSelectPin,
  // Device configuration of the addressed area
  input  wire ebl_pkg::ebl_width_t         devWidth,
  input  wire ebl_pkg::ebl_kind_t          devKind,
  // Internal request
  input  wire logic                        reqValid,
  output logic                             reqReady,
  input  wire ebl_pkg::ebl_req_t           req,
  // Internal answer
  output logic                             rspValid,
  output logic                             rspError,
  output logic [31:0]                      rspRdata,
  // External cycle
  output logic                             extValid,
  input  wire logic                        extReady,
  output logic                             extWrite,
  output logic [ebl_pkg::ADDR_W-1:0]       extAddr,
  // External data bus, three-signal form
  output logic [31:0]                      extDataOut,
  output logic                             extDataOeN,
  input  wire logic [31:0]                 extDataIn,
  // Lane strobes, active high
  output logic [ebl_pkg::LANES-1:0]        writeStrobeLane,
  output logic [ebl_pkg::LANES-1:0]        sdramMaskLane,
  // Byte order in force
  output logic                             bigEndian
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Lane that carries byte address b on a device of width w
  function automatic logic [1:0] laneOf(input logic [1:0] b,
                                        input logic [1:0] w,
                                        input logic       big);
    logic [1:0] m;
    m = (w == 2'h2) ? 2'h3 : ((w == 2'h1) ? 2'h1 : 2'h0);
    laneOf = big ? (m - (b & m)) : (b & m);
  endfunction

  // Width and kind combinations the bus can drive
  function automatic logic cfgOk(input logic [1:0] w, input logic [1:0] k);
    unique case (k)
      2'h1:    cfgOk = (w == 2'h1) || (w == 2'h2);
      2'h2:    cfgOk = (w == 2'h0) || (w == 2'h1);
      2'h0:    cfgOk = (w <= 2'h2);
      default: cfgOk = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  ebl_pkg::ebl_state_t state_r, state_nxt;
  ebl_pkg::ebl_req_t   req_r, req_nxt;
  logic [1:0]          idx_r, idx_nxt;
  logic [1:0]          wid_r, wid_nxt;
  logic                sdr_r, sdr_nxt;
  logic                big_r, big_nxt;
  logic                err_r, err_nxt;
  logic [31:0]         rd_r, rd_nxt;
  logic [31:0]         dOut_r, dOut_nxt;
  logic [3:0]          lane_r, lane_nxt;
  logic [ebl_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic [2:0]          extCnt_r, extCnt_nxt;

  // Derived figures for the current access
  logic [1:0] cycLog;
  logic [1:0] lastIdx;
  logic       accept;
  logic       reqBad;

  // Lane placement of the chunk for cycle index i
  function automatic void place(input ebl_pkg::ebl_req_t r,
                                input logic [1:0] i,
                                input logic [1:0] w,
                                input logic       big,
                                output logic [31:0] d,
                                output logic [3:0]  en,
                                output logic [ebl_pkg::ADDR_W-1:0] a);
    logic [1:0] cl;
    logic [1:0] nb;
    logic [1:0] cnt;
    logic [1:0] base;
    logic [1:0] bAddr;
    logic [1:0] ln;
    cl    = (r.size < w) ? r.size : w[1:0];
    nb    = 2'((3'h1 << cl) - 3'h1);
    cnt   = 2'((3'h1 << (r.size - cl)) - 3'h1);
    // Big endian sends the most significant chunk first
    base  = big ? 2'((cnt - i) << cl) : 2'(i << cl);
    a     = r.addr + ebl_pkg::ADDR_W'(i << cl);
    d     = 32'h0;
    en    = 4'h0;
    for (int j = 0; j < 4; j++) begin
      if (2'(j) <= nb) begin
        bAddr = big ? 2'(a[1:0] + nb - 2'(j)) : 2'(a[1:0] + 2'(j));
        ln    = laneOf(bAddr, w, big);
        d[ln*8 +: 8] = r.wdata[(base + 2'(j))*8 +: 8];
        en[ln] = 1'b1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic of the sequencer

  always_comb begin
    logic [31:0] d;
    logic [3:0]  en;
    logic [ebl_pkg::ADDR_W-1:0] a;
    logic [1:0]  lgS;
    logic        mis;
    d   = 32'h0;
    en  = 4'h0;
    a   = '0;
    lgS = req.size;
    mis = ((lgS == 2'h1) && req.addr[0]) ||
          ((lgS == 2'h2) && (req.addr[1:0] != 2'h0));
    reqBad = !cfgOk(devWidth, devKind) || (lgS == 2'h3) || mis;
    accept = reqValid && (state_r == ebl_pkg::ST_IDLE);
    cycLog = (req_r.size < wid_r) ? req_r.size : wid_r;
    lastIdx = 2'((3'h1 << (req_r.size - cycLog)) - 3'h1);
    state_nxt  = state_r;
    req_nxt    = req_r;
    idx_nxt    = idx_r;
    wid_nxt    = wid_r;
    sdr_nxt    = sdr_r;
    err_nxt    = err_r;
    rd_nxt     = rd_r;
    dOut_nxt   = dOut_r;
    lane_nxt   = lane_r;
    addr_nxt   = addr_r;
    extCnt_nxt = extCnt_r;
    unique case (state_r)
      ebl_pkg::ST_IDLE: begin
        if (accept) begin
          req_nxt    = req;
          idx_nxt    = 2'h0;
          wid_nxt    = devWidth;
          sdr_nxt    = (devKind == ebl_pkg::KIND_SDRAM);
          err_nxt    = reqBad;
          rd_nxt     = 32'h0;
          extCnt_nxt = 3'h0;
          place(req, 2'h0, devWidth, big_r, d, en, a);
          dOut_nxt   = d;
          lane_nxt   = en;
          addr_nxt   = a;
          state_nxt  = reqBad ? ebl_pkg::ST_RESP : ebl_pkg::ST_RUN;
        end
      end
      ebl_pkg::ST_RUN: begin
        if (extReady) begin
          extCnt_nxt = extCnt_r + 3'h1;
          // Gather read bytes back from the lanes just used
          for (int j = 0; j < 4; j++) begin
            if (lane_r[j]) begin
              rd_nxt = rd_nxt | ({24'h0, extDataIn[j*8 +: 8]} <<
                       (8 * int'(rdPos(j))));
            end
          end
          if (idx_r == lastIdx) begin
            state_nxt = ebl_pkg::ST_RESP;
          end else begin
            // Next chunk follows at once, no software step
            idx_nxt = idx_r + 2'h1;
            place(req_r, idx_r + 2'h1, wid_r, big_r, d, en, a);
            dOut_nxt = d;
            lane_nxt = en;
            addr_nxt = a;
          end
        end
      end
      ebl_pkg::ST_RESP: begin
        state_nxt = ebl_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = ebl_pkg::ST_IDLE;
      end
    endcase
  end

  // Result byte that lane j of the current cycle fills
  function automatic logic [1:0] rdPos(input int j);
    logic [1:0] cl;
    logic [1:0] nb;
    logic [1:0] base;
    logic [1:0] jb;
    rdPos = 2'h0;
    cl   = (req_r.size < wid_r) ? req_r.size : wid_r;
    nb   = 2'((3'h1 << cl) - 3'h1);
    base = big_r ? 2'((lastIdx - idx_r) << cl) : 2'(idx_r << cl);
    for (int k = 0; k < 4; k++) begin
      if (2'(k) <= nb) begin
        jb = big_r ? 2'(addr_r[1:0] + nb - 2'(k))
                   : 2'(addr_r[1:0] + 2'(k));
        if (int'(laneOf(jb, wid_r, big_r)) == j) begin
          rdPos = base + 2'(k);
        end
      end
    end
  endfunction

  // Byte order is caught only while reset is held, then kept
  always_comb begin
    big_nxt = big_r;
    if (srst) begin
      big_nxt = (endianSelectPin == ebl_pkg::ENDIAN_PIN_BIG);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk) begin
    big_r <= big_nxt;
    if (srst) begin
      state_r  <= ebl_pkg::ST_IDLE;
      req_r    <= '0;
      idx_r    <= 2'h0;
      wid_r    <= 2'h0;
      sdr_r    <= 1'b0;
      err_r    <= 1'b0;
      rd_r     <= 32'h0;
      dOut_r   <= 32'h0;
      lane_r   <= 4'h0;
      addr_r   <= '0;
      extCnt_r <= 3'h0;
    end else begin
      state_r  <= state_nxt;
      req_r    <= req_nxt;
      idx_r    <= idx_nxt;
      wid_r    <= wid_nxt;
      sdr_r    <= sdr_nxt;
      err_r    <= err_nxt;
      rd_r     <= rd_nxt;
      dOut_r   <= dOut_nxt;
      lane_r   <= lane_nxt;
      addr_r   <= addr_nxt;
      extCnt_r <= extCnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Strobes only on lanes of the running cycle; masks also on reads
  logic running;
  assign running         = (state_r == ebl_pkg::ST_RUN);
  assign reqReady        = (state_r == ebl_pkg::ST_IDLE);
  assign rspValid        = (state_r == ebl_pkg::ST_RESP);
  assign rspError        = rspValid && err_r;
  assign rspRdata        = rd_r;
  assign extValid        = running;
  assign extWrite        = req_r.write;
  assign extAddr         = addr_r;
  assign extDataOut      = dOut_r;
  assign extDataOeN      = !(running && req_r.write);
  assign writeStrobeLane = (running && req_r.write && !sdr_r) ?
                           lane_r : 4'h0;
  assign sdramMaskLane   = (running && sdr_r) ? lane_r : 4'h0;
  assign bigEndian       = big_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence sAccLong16Big;
    accept && !reqBad && (req.size == ebl_pkg::SZ_LONG) &&
    (devWidth == ebl_pkg::DW_16) && big_r;
  endsequence

  sequence sFirstHalf;
    extValid && (extDataOut[15:0] == $past(req.wdata[31:16])) &&
    (lane_r == 4'h3);
  endsequence

  endian_held_a: assert property (@(posedge clk) disable iff (srst)
    $stable(bigEndian)) else $error("byte order changed after reset");
  endian_strap_a: assert property (@(posedge clk)
    $past(srst) && !srst |-> bigEndian == !$past(endianSelectPin))
    else $error("byte order does not follow strap");
  long_first_half_a: assert property (@(posedge clk)
    disable iff (srst) sAccLong16Big |=> sFirstHalf)
    else $error("16-bit longword first cycle wrong");
  cycle_count_a: assert property (@(posedge clk)
    disable iff (srst) rspValid && !rspError |->
    extCnt_r == 3'(lastIdx) + 3'h1)
    else $error("wrong number of external cycles");
  long_w32_a: assert property (@(posedge clk)
    disable iff (srst) extValid && wid_r == 2'h2 &&
    req_r.size == ebl_pkg::SZ_LONG |-> lane_r == 4'hf && idx_r == lastIdx)
    else $error("32-bit longword not single full cycle");
  byte_w8_a: assert property (@(posedge clk) disable iff (srst)
    extValid && wid_r == 2'h0 |-> lane_r == 4'h1)
    else $error("8-bit device off lane 0");
  byte_w32_a: assert property (@(posedge clk) disable iff (srst)
    extValid && wid_r == 2'h2 && big_r && req_r.size == ebl_pkg::SZ_BYTE
    |-> lane_r == (4'h8 >> addr_r[1:0]))
    else $error("32-bit big endian byte lane wrong");
  byte_w16_a: assert property (@(posedge clk) disable iff (srst)
    extValid && wid_r == 2'h1 && big_r && req_r.size == ebl_pkg::SZ_BYTE
    |-> lane_r == (addr_r[0] ? 4'h1 : 4'h2))
    else $error("16-bit big endian byte lane wrong");
  sdram_cfg_a: assert property (@(posedge clk) disable iff (srst)
    accept && devKind == ebl_pkg::KIND_SDRAM && devWidth == ebl_pkg::DW_8
    |=> rspError) else $error("byte-wide SDRAM accepted");

  strobe_idle_a: assert property (@(posedge clk) disable iff (srst)
    !extValid |-> writeStrobeLane == 4'h0 && sdramMaskLane == 4'h0)
    else $error("strobe outside an external cycle");

endmodule

// ==== tb/ebl_mem_model.sv ====
// Far-side memory model for the lane aligner bench.
// Assumes one clock; answers each external cycle after slowWait+1 cycles,
// logs every finished cycle and returns an address-coded read pattern.
`timescale 1ns/100ps
module ebl_mem_model (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       srst,
  // Answer delay in cycles
  input  wire logic [3:0]                 slowWait,
  // External cycle from the aligner
  input  wire logic                       extValid,
  input  wire logic [ebl_pkg::ADDR_W-1:0] extAddr,
  input  wire logic [31:0]                extDataOut,
  input  wire logic                       extWrite,
  input  wire logic                       extDataOeN,
  input  wire logic [3:0]                 writeStrobeLane,
  input  wire logic [3:0]                 sdramMaskLane,
  output logic                            extReady,
  output logic [31:0]                     extDataIn
);
  logic [3:0]                 waitCnt;
  logic [31:0]                lastData;
  logic [31:0]                rdPat;
  logic [ebl_pkg::ADDR_W-1:0] logAddr [16];
  logic [31:0]                logData [16];
  logic [3:0]                 logStrb [16];
  logic [3:0]                 logMask [16];
  logic [1:0]                 logDir  [16];
  int                         logCnt;

  ////////////////////////////////////////////////////////////////////////////
  // Each lane byte names its address and lane, so misplaced bytes show
  assign rdPat = {extAddr[5:0], 2'h3, extAddr[5:0], 2'h2,
                  extAddr[5:0], 2'h1, extAddr[5:0], 2'h0};

  // Released bus shows the inverse of the last value, never stale data
  always_comb begin
    extDataIn = extReady ? rdPat : ~lastData;
  end

  // Answer after the wait, then log the finished cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      extReady <= 1'b0;
      waitCnt  <= 4'h0;
      logCnt   <= 0;
      lastData <= 32'h0;
    end else if (extValid && extReady) begin
      logAddr[logCnt[3:0]] <= extAddr;
      logData[logCnt[3:0]] <= extDataOut;
      logStrb[logCnt[3:0]] <= writeStrobeLane;
      logMask[logCnt[3:0]] <= sdramMaskLane;
      logDir[logCnt[3:0]]  <= {extWrite, extDataOeN};
      logCnt   <= logCnt + 1;
      extReady <= 1'b0;
      lastData <= rdPat;
    end else if (extValid && waitCnt == slowWait) begin
      extReady <= 1'b1;
      waitCnt  <= 4'h0;
    end else if (extValid) begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the external bus lane aligner.
// Assumes the memory model logs each external cycle it answers.
`timescale 1ns/100ps
module tb_top;
  logic clk, srst, pin, reqValid, reqReady, rspValid, rspError, bigEndian;
  logic extValid, extReady, gotErr, curWr, extWrite, extDataOeN;
  logic [3:0] slowWait, writeStrobeLane, sdramMaskLane;
  logic [31:0] rspRdata, extDataOut, extDataIn, gotData;
  logic [25:0] extAddr;
  ebl_pkg::ebl_width_t devWidth;
  ebl_pkg::ebl_kind_t  devKind;
  ebl_pkg::ebl_req_t   req;
  int err_count, n_compared, b0;

  ebl_lane_align DUT (.clk(clk), .srst(srst), .endianSelectPin(pin),
    .devWidth(devWidth), .devKind(devKind), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .rspValid(rspValid),
    .rspError(rspError), .rspRdata(rspRdata), .extValid(extValid),
    .extReady(extReady), .extWrite(extWrite), .extAddr(extAddr),
    .extDataOut(extDataOut), .extDataOeN(extDataOeN),
    .extDataIn(extDataIn),
    .writeStrobeLane(writeStrobeLane), .sdramMaskLane(sdramMaskLane),
    .bigEndian(bigEndian));
  ebl_mem_model MEM (.clk(clk), .srst(srst), .slowWait(slowWait),
    .extValid(extValid), .extAddr(extAddr), .extDataOut(extDataOut),
    .extWrite(extWrite), .extDataOeN(extDataOeN),
    .writeStrobeLane(writeStrobeLane), .sdramMaskLane(sdramMaskLane),
    .extReady(extReady), .extDataIn(extDataIn));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task step;
    @(posedge clk);
    #1;
  endtask

  task wrap_up;
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chkv(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strap is held steady for the whole reset, as the board must
  task do_reset(input logic lvl);
    srst = 1'b1;
    pin  = lvl;
    repeat (16) step;
    srst = 1'b0;
    step;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One internal access, bounded waits for take and answer
  task automatic xfer(input logic wr, input ebl_pkg::ebl_size_t sz,
                      input logic [25:0] a, input logic [31:0] wd,
                      input ebl_pkg::ebl_width_t dw,
                      input ebl_pkg::ebl_kind_t kd);
    int i;
    b0 = MEM.logCnt;
    curWr = wr;
    devWidth = dw;
    devKind  = kd;
    req.write = wr;
    req.size  = sz;
    req.addr  = a;
    req.wdata = wd;
    reqValid = 1'b1;
    for (i = 0; reqReady !== 1'b1 && i < 20; i++) step;
    if (i >= 20) begin
      err_count++;
      wrap_up;
    end else begin
      step;
      reqValid = 1'b0;
      for (i = 0; rspValid !== 1'b1 && i < 200; i++) step;
      if (i >= 200) begin
        err_count++;
        wrap_up;
      end else begin
        gotErr  = rspError;
        gotData = rspRdata;
      end
    end
  endtask

  // Checks logged cycle i: address, active lanes, idle lanes, lane data
  task automatic chkCyc(input int i, input logic [25:0] a,
                        input logic [3:0] s, input logic [31:0] d,
                        input bit sd);
    logic [31:0] m;
    int k;
    k = (b0 + i) % 16;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    chkv(32'(MEM.logAddr[k]), 32'(a));
    chkv(32'(sd ? MEM.logMask[k] : MEM.logStrb[k]), 32'(s));
    chkv(32'(sd ? MEM.logStrb[k] : MEM.logMask[k]), 32'h0);
    chkv(MEM.logData[k] & m, d & m);
    // Bus is driven, and write flagged, only on write cycles
    chkv(32'(MEM.logDir[k]), curWr ? 32'h2 : 32'h1);
  endtask

  task chkn(input int n);
    chkv(32'(MEM.logCnt - b0), 32'(n));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Strap latch and byte order
  task t_endian;
    do_reset(1'b1);
    pin = 1'b0;
    repeat (3) step;
    chkv(32'(bigEndian), 32'h0);
    xfer(1'b1, ebl_pkg::SZ_BYTE, 26'h0, 32'h5a, ebl_pkg::DW_32,
         ebl_pkg::KIND_NORMAL);
    chkCyc(0, 26'h0, 4'h1, 32'h5a, 0);
    do_reset(1'b0);
    pin = 1'b1;
    repeat (3) step;
    chkv(32'(bigEndian), 32'h1);
  endtask

  // 32-bit device: every byte offset, both words, one longword
  task t_w32;
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, ebl_pkg::SZ_BYTE, 26'h100 + 26'(k), 32'h3c,
           ebl_pkg::DW_32, ebl_pkg::KIND_NORMAL);
      chkn(1);
      chkCyc(0, 26'h100 + 26'(k), 4'h8 >> k,
             32'h3c << (8 * (3 - k)), 0);
    end
    xfer(1'b1, ebl_pkg::SZ_WORD, 26'h100, 32'h1234, ebl_pkg::DW_32,
         ebl_pkg::KIND_NORMAL);
    chkCyc(0, 26'h100, 4'hc, 32'h12340000, 0);
    xfer(1'b1, ebl_pkg::SZ_WORD, 26'h102, 32'h5678, ebl_pkg::DW_32,
         ebl_pkg::KIND_NORMAL);
    chkCyc(0, 26'h102, 4'h3, 32'h5678, 0);
    xfer(1'b1, ebl_pkg::SZ_LONG, 26'h104, 32'ha1b2c3d4, ebl_pkg::DW_32,
         ebl_pkg::KIND_NORMAL);
    chkn(1);
    chkCyc(0, 26'h104, 4'hf, 32'ha1b2c3d4, 0);
  endtask

  // 16-bit device: bytes, word, split longword
  task t_w16;
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, ebl_pkg::SZ_BYTE, 26'h200 + 26'(k), 32'h96,
           ebl_pkg::DW_16, ebl_pkg::KIND_NORMAL);
      chkCyc(0, 26'h200 + 26'(k), k[0] ? 4'h1 : 4'h2,
             k[0] ? 32'h96 : 32'h9600, 0);
    end
    xfer(1'b1, ebl_pkg::SZ_WORD, 26'h202, 32'hbeef, ebl_pkg::DW_16,
         ebl_pkg::KIND_NORMAL);
    chkCyc(0, 26'h202, 4'h3, 32'hbeef, 0);
    xfer(1'b1, ebl_pkg::SZ_LONG, 26'h204, 32'hcafe1234, ebl_pkg::DW_16,
         ebl_pkg::KIND_NORMAL);
    chkn(2);
    chkCyc(0, 26'h204, 4'h3, 32'hcafe, 0);
    chkCyc(1, 26'h206, 4'h3, 32'h1234, 0);
  endtask

  // 8-bit device with a slow answer: four byte cycles, MSB first
  task t_w8;
    slowWait = 4'h3;
    xfer(1'b1, ebl_pkg::SZ_LONG, 26'h300, 32'ha1b2c3d4, ebl_pkg::DW_8,
         ebl_pkg::KIND_NORMAL);
    chkn(4);
    for (int k = 0; k < 4; k++) begin
      chkCyc(k, 26'h300 + 26'(k), 4'h1,
             32'ha1b2c3d4 >> (8 * (3 - k)), 0);
    end
    slowWait = 4'h0;
  endtask

  // Reads are reassembled from the lane pattern of each cycle
  task t_reads;
    xfer(1'b0, ebl_pkg::SZ_LONG, 26'h10, 32'h0, ebl_pkg::DW_16,
         ebl_pkg::KIND_NORMAL);
    chkv(gotData, 32'h41404948);
    chkn(2);
    chkCyc(1, 26'h12, 4'h0, 32'h0, 0);
    xfer(1'b0, ebl_pkg::SZ_LONG, 26'h20, 32'h0, ebl_pkg::DW_8,
         ebl_pkg::KIND_NORMAL);
    chkv(gotData, 32'h8084888c);
    xfer(1'b0, ebl_pkg::SZ_LONG, 26'h30, 32'h0, ebl_pkg::DW_32,
         ebl_pkg::KIND_NORMAL);
    chkv(gotData, 32'hc3c2c1c0);
  endtask

  // Device kinds: SDRAM masks, widths each kind refuses
  task t_kinds;
    xfer(1'b1, ebl_pkg::SZ_WORD, 26'h50, 32'h7788, ebl_pkg::DW_16,
         ebl_pkg::KIND_SDRAM);
    chkCyc(0, 26'h50, 4'h3, 32'h7788, 1);
    xfer(1'b0, ebl_pkg::SZ_LONG, 26'h60, 32'h0, ebl_pkg::DW_32,
         ebl_pkg::KIND_SDRAM);
    chkCyc(0, 26'h60, 4'hf, 32'h0, 1);
    xfer(1'b1, ebl_pkg::SZ_BYTE, 26'h70, 32'h11, ebl_pkg::DW_8,
         ebl_pkg::KIND_SDRAM);
    chkv(32'(gotErr), 32'h1);
    chkn(0);
    xfer(1'b1, ebl_pkg::SZ_BYTE, 26'h70, 32'h11, ebl_pkg::DW_32,
         ebl_pkg::KIND_PCMCIA);
    chkv(32'(gotErr), 32'h1);
    chkn(0);
    xfer(1'b1, ebl_pkg::SZ_WORD, 26'h72, 32'h2233, ebl_pkg::DW_8,
         ebl_pkg::KIND_PCMCIA);
    chkv(32'(gotErr), 32'h0);
    chkn(2);
    // Misaligned word and an unknown device kind are refused
    xfer(1'b1, ebl_pkg::SZ_WORD, 26'h71, 32'h11, ebl_pkg::DW_16,
         ebl_pkg::KIND_NORMAL);
    chkv(32'(gotErr), 32'h1);
    chkn(0);
    xfer(1'b1, ebl_pkg::SZ_BYTE, 26'h70, 32'h11, ebl_pkg::DW_16,
         ebl_pkg::ebl_kind_t'(2'h3));
    chkv(32'(gotErr), 32'h1);
    chkn(0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    err_count  = 0;
    n_compared = 0;
    reqValid   = 1'b0;
    slowWait   = 4'h0;
    devWidth   = ebl_pkg::DW_32;
    devKind    = ebl_pkg::KIND_NORMAL;
    req        = '0;
    do_reset(1'b0);
    t_endian;
    do_reset(1'b0);
    t_w32;
    t_w16;
    t_w8;
    t_reads;
    t_kinds;
    wrap_up;
  end
endmodule
